// ### design/tmz_timer0.sv
// Timer/counter core with Avalon-MM register slave
//
// How it works
// RULE1 - Timer mode without prescaler adds one each instruction cycle.
// RULE2 - A counter write holds counting for two instruction cycles.
// RULE3 - Source select, comparator count select and pin enable set: count pin edges.
// RULE4 - Edge select clear counts rising edges, set counts falling edges.
// RULE5 - Source set, comparator count select clear: count comparator output.
// RULE6 - One prescaler serves counter or watchdog, chosen by assign bit.
// RULE7 - Counter prescale ratios run 1:2 to 1:256 in powers of two.
// RULE8 - Prescaler count cannot be read or written by software.
// RULE9 - Counter writes clear the prescaler while it serves the counter.
// RULE10 - Watchdog clear clears the prescaler while it serves the watchdog.
// RULE11 - Reset clears the prescaler count.
// RULE12 - Count source is sampled on phase two and phase four.
// RULE13 - Without prescaler, pin stays high and low at least 2 Tosc each.
// RULE14 - With prescaler, pin period at least 4 Tosc over the ratio.
// RULE15 - Increment follows a pin edge by 3 to 7 Tosc.
// RULE16 - The prescaler is an 8-bit counter.
// RULE17 - Software follows the clear sequence before moving prescaler to watchdog.
// RULE18 - Software clears watchdog before moving prescaler to the counter.
// RULE19 - Source select set overrides the count pin direction control.
// RULE20 - Rate field n selects a ratio of two to the n plus one.
// RULE21 - The counter wraps from all ones to zero and keeps going.
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tmz_timer0 (
  input  wire logic                         MCLK,
  input  wire logic                         RESETN,
  input  wire logic [tmz_pkg::ADDR_W-1:0]   AVS_ADDRESS,
  input  wire logic                         AVS_READ,
  input  wire logic                         AVS_WRITE,
  input  wire logic [tmz_pkg::DATA_W-1:0]   AVS_WRITEDATA,
  input  wire logic [3:0]                   AVS_BYTEENABLE,
  output wire logic [tmz_pkg::DATA_W-1:0]   AVS_READDATA,
  output wire logic                         AVS_WAITREQUEST,
  input  wire logic                         EXT_COUNT_PIN,
  input  wire logic                         COMP1_OUT,
  input  wire logic                         WDT_CLEAR_INSTR,
  input  wire logic                         WDT_TICK,
  output wire logic                         WDT_POSTSCALED,
  output wire logic                         PIN_DIR_OVERRIDE,
  output wire logic [7:0]                   TIMER_VALUE
);
  import tmz_pkg::*;

  tmz_link_if lk ();

  tmz_core_t st;
  tmz_core_t next_st;

  logic bus_req;
  logic bus_done;
  logic tmr_wr;
  logic cmp_wr;
  logic opt_wr;
  logic tmr_mode;
  logic ext_mode;
  logic comp_mode;
  logic src_raw;
  logic cnt_src;
  logic strobe;
  logic inc;

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [3:0] off);
    hit = (addr == off);
  endfunction

  // Read view; the prescaler count has no address at all
  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] addr,
                                                 input tmz_core_t s,
                                                 input logic cout);
    read_mux = 32'h0000_0000;
    if (hit(addr, OFF_TMR)) begin
      read_mux[7:0] = s.tmr;
    end else if (hit(addr, OFF_CMP)) begin
      read_mux[7:0] = {cout, s.cmp[6:0]};
    end
  endfunction

  // Phase generator and shared prescaler
  tmz_phase u_phase (
    .MCLK   (MCLK),
    .RESETN (RESETN),
    .lk     (lk.phase)
  );

  tmz_presc u_presc (
    .MCLK   (MCLK),
    .RESETN (RESETN),
    .lk     (lk.presc)
  );

  // Bus handshake: one wait cycle, then the access completes
  assign bus_req  = AVS_READ | AVS_WRITE;
  assign bus_done = bus_req & st.ack;
  assign tmr_wr   = bus_done & AVS_WRITE & AVS_BYTEENABLE[0] & hit(AVS_ADDRESS, OFF_TMR);
  assign cmp_wr   = bus_done & AVS_WRITE & AVS_BYTEENABLE[0] & hit(AVS_ADDRESS, OFF_CMP);
  assign opt_wr   = bus_done & AVS_WRITE & AVS_BYTEENABLE[0] & hit(AVS_ADDRESS, OFF_OPT);

  // Clock source selection
  assign tmr_mode  = ~st.opt[OPT_CS];                                  // see RULE1
  assign ext_mode  = st.opt[OPT_CS] & st.cmp[CMP_CLOCK_SOURCE_SELECT] & st.cmp[CMP_OUTEN]; // see RULE3
  assign comp_mode = st.opt[OPT_CS] & ~st.cmp[CMP_CLOCK_SOURCE_SELECT];               // see RULE5

  always_comb begin
    if (tmr_mode) begin
      src_raw = lk.iclk;
    end else if (ext_mode) begin
      src_raw = EXT_COUNT_PIN ^ st.opt[OPT_SE];                        // see RULE4
    end else if (comp_mode) begin
      src_raw = COMP1_OUT;                                             // see RULE5
    end else begin
      src_raw = 1'b0;
    end
  end

  // Prescaler routing and clearing
  assign lk.src      = src_raw;
  assign lk.prescaler_assign      = st.opt[OPT_PSA];                                // see RULE6
  assign lk.rate     = st.opt[OPT_PS +: 3];                            // see RULE7
  assign lk.wdt_tick = WDT_TICK;
  assign lk.clr      = (tmr_wr & ~st.opt[OPT_PSA])                     // see RULE9
                     | (WDT_CLEAR_INSTR & st.opt[OPT_PSA]);            // see RULE10
  assign cnt_src     = st.opt[OPT_PSA] ? src_raw : lk.div_out;

  // Synchroniser strobes and the gated increment
  assign strobe = lk.q2 | lk.q4;                                       // see RULE12
  assign inc    = strobe & st.pend & (st.inhib == 4'h0);               // see RULE2

  // Next state: sampling, counting, register writes and bus reply
  always_comb begin
    next_st     = st;
    next_st.ack = bus_req & ~st.ack;
    if (bus_req & ~st.ack) begin
      next_st.rdata = read_mux(AVS_ADDRESS, st, COMP1_OUT);            // see RULE8
    end
    if (st.inhib != 4'h0) begin
      next_st.inhib = 4'(st.inhib - 4'h1);
    end
    // A rise seen at one strobe is applied at the next one
    if (strobe) begin
      next_st.smp  = cnt_src;                                          // see RULE12
      next_st.pend = cnt_src & ~st.smp;                                // see RULE15
    end
    if (inc) begin
      next_st.tmr = 8'(st.tmr + 8'h01);                                // see RULE21
    end
    // Software write wins over a same-cycle increment
    if (tmr_wr) begin
      next_st.tmr   = AVS_WRITEDATA[7:0];
      next_st.inhib = INHIBIT_CYC;                                     // see RULE2
      next_st.pend  = 1'b0;
    end
    if (cmp_wr) begin
      next_st.cmp = AVS_WRITEDATA[7:0];
    end
    if (opt_wr) begin
      next_st.opt = AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      st <= CORE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign AVS_WAITREQUEST  = bus_req & ~st.ack;
  assign AVS_READDATA     = st.rdata;
  assign WDT_POSTSCALED   = lk.wdt_out;
  assign PIN_DIR_OVERRIDE = st.opt[OPT_CS];                            // see RULE19
  assign TIMER_VALUE      = st.tmr;

  // Steady timer mode without prescaler
  sequence timer_steady_s;
    (tmr_mode && st.opt[OPT_PSA] && st.inhib == 4'h0 && !tmr_wr && !opt_wr)[*8];
  endsequence

  // A counter write followed by a cycle with no counter write
  sequence tmr_write_s;
    tmr_wr ##1 (tmr_wr == 1'b0);
  endsequence

  // Pin edge in counter mode with no prescaler and no pending write
  sequence pin_edge_s;
    ext_mode && st.opt[OPT_PSA] && $changed(src_raw) && src_raw && st.inhib == 4'h0 && !tmr_wr;
  endsequence

  timer_rate_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    timer_steady_s |-> st.tmr == 8'($past(st.tmr, 4) + 8'h01)) else $error("timer rate wrong"); // see RULE1

  write_hold_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    tmr_wr |=> !inc [*8]) else $error("count during write inhibit"); // see RULE2

  write_load_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    tmr_write_s |-> st.tmr == $past(AVS_WRITEDATA[7:0])) else $error("written value lost"); // see RULE2

  ext_source_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    ext_mode |-> src_raw == (EXT_COUNT_PIN ^ st.opt[OPT_SE])) else $error("pin edge select wrong"); // see RULE4

  edge_delay_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    pin_edge_s |-> ##[1:6] inc) else $error("pin edge not counted in time"); // see RULE15

  comp_source_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    comp_mode |-> src_raw == COMP1_OUT) else $error("comparator source wrong"); // see RULE5

  strobe_only_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    inc |-> lk.q2 || lk.q4) else $error("increment off sample phase"); // see RULE12

  counter_wrap_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    inc && !tmr_wr && st.tmr == 8'hFF |=> st.tmr == 8'h00) else $error("counter wrap wrong"); // see RULE21

  psc_tmr_clr_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    tmr_wr && !st.opt[OPT_PSA] |-> lk.clr) else $error("write did not clear prescaler"); // see RULE9

  psc_wdt_clr_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    WDT_CLEAR_INSTR && st.opt[OPT_PSA] |-> lk.clr) else $error("watchdog clear missed prescaler"); // see RULE10

  dir_override_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    opt_wr && AVS_WRITEDATA[OPT_CS] |=> PIN_DIR_OVERRIDE) else $error("direction not overridden"); // see RULE19
endmodule

// ### pkg/tmz_pkg.sv
// Constants, register map and state types of the timer/counter block
package tmz_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [3:0] OFF_TMR = 4'h0;
  localparam logic [3:0] OFF_CMP = 4'h4;
  localparam logic [3:0] OFF_OPT = 4'h8;

  // option_config field positions
  localparam int unsigned OPT_CS  = 5;
  localparam int unsigned OPT_SE  = 4;
  localparam int unsigned OPT_PSA = 3;
  localparam int unsigned OPT_PS  = 0;

  // comparator1_control field positions
  localparam int unsigned CMP_OUT   = 7;
  localparam int unsigned CMP_OUTEN = 6;
  localparam int unsigned CMP_CLOCK_SOURCE_SELECT  = 4;

  // Values after reset
  localparam logic [7:0] RST_TMR = 8'h00;
  localparam logic [7:0] RST_OPT = 8'hFF;
  localparam logic [7:0] RST_CMP = 8'hFF;
  localparam logic [7:0] RST_PSC = 8'h00;

  // Timing: one clock is one oscillator period (Tosc)
  localparam int unsigned CLK_NS        = 20;
  localparam int unsigned TOSC_NS       = 20;
  localparam int unsigned PHASES        = 4;
  localparam int unsigned INHIBIT_INSTR = 2;
  localparam logic [3:0]  INHIBIT_CYC   = 4'((INHIBIT_INSTR * PHASES * TOSC_NS) / CLK_NS);

  // Four phases of one instruction cycle, Gray coded
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } tmz_phase_t;

  typedef struct packed {
    tmz_phase_t ph;
  } tmz_phase_st_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       src_q;
    logic       tick_q;
    logic       sel_q;
    logic       wdt_out;
  } tmz_presc_t;

  typedef struct packed {
    logic [7:0]        tmr;
    logic [7:0]        opt;
    logic [7:0]        cmp;
    logic [3:0]        inhib;
    logic              smp;
    logic              pend;
    logic              ack;
    logic [DATA_W-1:0] rdata;
  } tmz_core_t;

  // Sampler starts high so a source already high after reset is not taken as a rise
  localparam tmz_core_t CORE_RST = '{tmr: RST_TMR, opt: RST_OPT, cmp: RST_CMP, inhib: 4'h0,
                                     smp: 1'b1, pend: 1'b0, ack: 1'b0, rdata: 32'h0000_0000};
  localparam tmz_presc_t PSC_RST = '{cnt: RST_PSC, src_q: 1'b0, tick_q: 1'b0, sel_q: 1'b0,
                                     wdt_out: 1'b0};
endpackage

// ### pkg/tmz_link_if.sv
// Signals shared by the core, the phase generator and the prescaler
`timescale 1ns/1ps
interface tmz_link_if;
  logic       q2;
  logic       q4;
  logic       iclk;
  logic       src;
  logic       clr;
  logic [2:0] rate;
  logic       prescaler_assign;
  logic       wdt_tick;
  logic       div_out;
  logic       wdt_out;

  modport phase (output q2, output q4, output iclk);
  modport presc (input src, input clr, input rate, input prescaler_assign, input wdt_tick,
                 output div_out, output wdt_out);
  modport core  (input q2, input q4, input iclk, input div_out, input wdt_out,
                 output src, output clr, output rate, output prescaler_assign, output wdt_tick);
endinterface

// ### design/tmz_phase.sv
// Four-phase instruction clock generator
`timescale 1ns/1ps
module tmz_phase (
  input wire logic MCLK,
  input wire logic RESETN,
  tmz_link_if.phase lk
);
  import tmz_pkg::*;

  tmz_phase_st_t st;
  tmz_phase_st_t next_st;

  // Step Q1 to Q4 and round again
  always_comb begin
    next_st = st;
    case (st.ph)
      PH_Q1:   next_st.ph = PH_Q2;
      PH_Q2:   next_st.ph = PH_Q3;
      PH_Q3:   next_st.ph = PH_Q4;
      PH_Q4:   next_st.ph = PH_Q1;
      default: next_st.ph = PH_Q1;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      st <= '{ph: PH_Q1};
    end else begin
      st <= next_st;
    end
  end

  // Sample strobes and the internal instruction clock
  assign lk.q2   = (st.ph == PH_Q2);
  assign lk.q4   = (st.ph == PH_Q4);
  assign lk.iclk = (st.ph == PH_Q1) || (st.ph == PH_Q2);

  phase_order_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    lk.q2 |-> ##2 lk.q4 ##2 lk.q2) else $error("phase strobes out of order"); // see RULE12
endmodule

// ### design/tmz_presc.sv
// Shared 8-bit prescaler / watchdog postscaler
`timescale 1ns/1ps
module tmz_presc (
  input wire logic MCLK,
  input wire logic RESETN,
  tmz_link_if.presc lk
);
  import tmz_pkg::*;

  tmz_presc_t st;
  tmz_presc_t next_st;
  logic       src_rise;
  logic       tick_rise;
  logic       sel;

  // Count source or watchdog ticks; clear wins over counting
  always_comb begin
    src_rise  = lk.src & ~st.src_q;
    tick_rise = lk.wdt_tick & ~st.tick_q;
    sel       = st.cnt[lk.rate];                       // see RULE20
    next_st        = st;
    next_st.src_q  = lk.src;
    next_st.tick_q = lk.wdt_tick;
    next_st.sel_q  = sel;
    next_st.wdt_out = tick_rise;
    if (lk.clr) begin
      next_st.cnt = 8'h00;                             // see RULE9 see RULE10
    end else if (lk.prescaler_assign ? tick_rise : src_rise) begin
      next_st.cnt = 8'(st.cnt + 8'h01);                // see RULE6 see RULE16
    end
    // Carry out of the selected bit is one postscaled pulse; a clear makes none
    if (lk.prescaler_assign) begin
      next_st.wdt_out = sel & ~next_st.cnt[lk.rate] & ~lk.clr;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      st <= PSC_RST;                                   // see RULE11
    end else begin
      st <= next_st;
    end
  end

  assign lk.div_out = st.cnt[lk.rate];                 // see RULE7
  assign lk.wdt_out = st.wdt_out;

  psc_clear_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    lk.clr |=> st.cnt == 8'h00) else $error("prescaler not cleared"); // see RULE9
  psc_owner_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    lk.prescaler_assign && !lk.clr && !tick_rise |=> $stable(st.cnt)) else $error("timer moved watchdog prescaler"); // see RULE6
endmodule

// ### verification/tmz_pulse_src.sv
// Model of the count pin source and comparator output
`timescale 1ns/1ps
module tmz_pulse_src (
  input  wire logic mclk,
  output logic      pin,
  output logic      cmp
);
  initial begin
    pin = 1'b0;
    cmp = 1'b0;
  end

  // Change both levels after an edge and hold them 2 Tosc
  task automatic put(input logic p, input logic c);
    @(posedge mclk);
    pin <= p;
    cmp <= c;
    repeat (2) @(posedge mclk);
  endtask
endmodule

// ### verification/tmz_timer0_tb.sv
// Register level tests of the timer/counter block
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
module tmz_timer0_tb;
  import tmz_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic [3:0]  ad;
  logic        rd;
  logic        wr;
  logic [31:0] wd;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wait_rq;
  logic        pin;
  logic        cmp;
  logic        clr;
  logic        tick;
  logic        wdt_post;
  logic        dir_ovr;
  logic [7:0]  tv;
  int          n_mismatch = 0;
  int          tests_run  = 0;
  int          n_pulse    = 0;

  tmz_timer0 u_tmz_timer0 (.MCLK(mclk), .RESETN(rst_n), .AVS_ADDRESS(ad), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_rq),
    .EXT_COUNT_PIN(pin), .COMP1_OUT(cmp), .WDT_CLEAR_INSTR(clr), .WDT_TICK(tick),
    .WDT_POSTSCALED(wdt_post), .PIN_DIR_OVERRIDE(dir_ovr), .TIMER_VALUE(tv));
  tmz_pulse_src u_tmz_pulse_src (.mclk(mclk), .pin(pin), .cmp(cmp));

  // Clock, 20 ns period
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Postscaled watchdog pulses
  always @(posedge mclk) begin
    if (wdt_post === 1'b1) n_pulse++;
  end

  // Bus write; hold until waitrequest is seen low
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    ad <= a;
    wd <= {24'h00_0000, d};
    be <= 4'hF;
    wr <= 1'b1;
    do begin
      @(posedge mclk);
    end while (wait_rq !== 1'b0);
    wr <= 1'b0;
    @(negedge mclk);
  endtask

  // Bus read and compare
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    @(posedge mclk);
    ad <= a;
    rd <= 1'b1;
    do begin
      @(posedge mclk);
    end while (wait_rq !== 1'b0);
    d = rdata;
    rd <= 1'b0;
    `CHK(d, e)
  endtask

  // Counter steady for two cycles after a source change, then moved by inc
  task automatic edge_chk(input logic [7:0] inc);
    logic [7:0] v0;
    v0 = tv;
    @(negedge mclk);
    `CHK(tv, v0)
    repeat (2) @(negedge mclk);
    `CHK(tv, 8'(v0 + inc))
  endtask

  // Increments seen over a span of cycles
  task automatic span_chk(input int cyc, input logic [7:0] inc);
    logic [7:0] v0;
    v0 = tv;
    repeat (cyc) @(negedge mclk);
    `CHK(tv, 8'(v0 + inc))
  endtask

  task automatic wdt_tick();
    @(posedge mclk);
    tick <= 1'b1;
    repeat (2) @(posedge mclk);
    tick <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic wdt_clr();
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog on the whole run
  initial begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    ad = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0000_0000;
    be = 4'h0;
    clr = 1'b0;
    tick = 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(OFF_TMR, 32'h0000_0000);
    rd_chk(OFF_CMP, 32'h0000_007F);
    rd_chk(OFF_OPT, 32'h0000_0000);
    rd_chk(4'hC, 32'h0000_0000);
    `CHK(dir_ovr, 1'b1)
    wr_reg(OFF_CMP, 8'hD0);
    rd_chk(OFF_CMP, 32'h0000_0050);
    $display("test registers done");
    wr_reg(OFF_OPT, 8'h08);
    `CHK(dir_ovr, 1'b0)
    wr_reg(OFF_TMR, 8'hFD);
    span_chk(6, 8'h00);
    repeat (6) @(negedge mclk);
    span_chk(40, 8'h0A);
    $display("test timer mode done");
    for (int n = 0; n < 8; n++) begin
      wr_reg(OFF_OPT, 8'(n));
      wr_reg(OFF_TMR, 8'h00);
      repeat (12) @(negedge mclk);
      span_chk(12 << (n + 1), 8'h03);
    end
    $display("test prescale ratios done");
    for (int s = 0; s < 2; s++) begin
      wr_reg(OFF_TMR, 8'h00);
      wr_reg(OFF_OPT, 8'h28 | 8'(s << 4));
      repeat (10) @(negedge mclk);
      u_tmz_pulse_src.put(1'b1, 1'b0);
      edge_chk(8'(s == 0));
      u_tmz_pulse_src.put(1'b0, 1'b0);
      edge_chk(8'(s == 1));
    end
    $display("test count pin done");
    for (int c = 0; c < 3; c++) begin
      wr_reg(OFF_CMP, c == 2 ? 8'h10 : 8'(c << 6));
      wr_reg(OFF_TMR, 8'h00);
      repeat (10) @(negedge mclk);
      u_tmz_pulse_src.put(1'b1, 1'b1);
      edge_chk(8'(c != 2));
      u_tmz_pulse_src.put(1'b0, 1'b0);
      u_tmz_pulse_src.put(1'b1, 1'b0);
      edge_chk(8'h00);
      u_tmz_pulse_src.put(1'b0, 1'b0);
    end
    $display("test comparator source done");
    wdt_clr();
    wr_reg(OFF_TMR, 8'h00);
    wr_reg(OFF_OPT, 8'h08);
    wdt_clr();
    n_pulse = 0;
    wdt_tick();
    wdt_tick();
    `CHK(n_pulse, 1)
    wdt_tick();
    wdt_clr();
    wdt_tick();
    `CHK(n_pulse, 1)
    wdt_tick();
    `CHK(n_pulse, 2)
    wdt_clr();
    wr_reg(OFF_OPT, 8'h00);
    wdt_tick();
    `CHK(n_pulse, 3)
    $display("test watchdog path done");
    complete_run();
  end
endmodule
